/* File: verilog/pwmo_top.v */
// PWM time base, independent and single-pulse output modes and manual
// override for three output pairs, with an AXI4-Lite register slave.
// Assumes all inputs synchronous to CLK; CE low freezes every register.
`timescale 1ns/1ns
`include "pwmo_regs.vh"
module pwmo_top
#(
	parameter CW = 12, // Time base and duty width
	parameter DW = 6 // Dead-time counter width
)
(
	input wire CLK,
	input wire RST,
	input wire CE,
	input wire [7:0] AWADDR,
	input wire AWVALID,
	output reg AWREADY,
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	input wire WVALID,
	output reg WREADY,
	output reg [1:0] BRESP,
	output reg BVALID,
	input wire BREADY,
	input wire [7:0] ARADDR,
	input wire ARVALID,
	output reg ARREADY,
	output reg [31:0] RDATA,
	output reg [1:0] RRESP,
	output reg RVALID,
	input wire RREADY,
	output reg [5:0] PWM_OUT,
	output reg IRQ
);

// Byte-lane merge of a write into a 32-bit register image
function [31:0] merge;
	input [31:0] old;
	input [31:0] data;
	input [3:0] strb;
	integer i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1)
			if (strb[i])
				merge[i*8 +: 8] = data[i*8 +: 8];
	end
endfunction

// Address decode, used for both the read and the write path
function mapped;
	input [7:0] a;
	begin
		mapped = (a[1:0] == 2'b00) && (a <= `PWMO_ADDR_COUNT);
	end
endfunction

// Software-visible registers
reg [1:0] mode_ff; // Time base mode field
reg en_ff; // Time base enable bit
reg [CW-1:0] period_ff; // Period value
reg [CW-1:0] duty_ff [0:2]; // Duty values 0..2
reg [2:0] indep_ff; // Pair independent select bits
reg sync_ff; // Override sync bit
reg high_side_polarity_ff; // High-side (odd) polarity
reg low_side_polarity_ff; // Low-side (even) polarity
reg [5:0] ovsel_ff; // Override select, active low
reg [5:0] ovstate_ff; // Manual state bits
reg [DW-1:0] dt_ff; // Dead time in clock cycles
reg [1:0] istat_ff; // Sticky interrupt status
reg [1:0] imask_ff; // Interrupt mask

// Time base and output state
reg [CW-1:0] cnt_ff; // Time base counter
reg down_ff; // Centre-aligned counting downward
reg en_prev_ff; // Enable seen last cycle, for start detect
reg [2:0] pulse_ff; // Single-pulse active flag per pair
reg [5:0] ovsel_act_ff; // Override select now in force
reg [5:0] ovstate_act_ff; // Manual state now in force
reg [5:0] req_ff; // Wanted active level per pin before dead time

// Bus slave state
reg aw_have_ff;
reg w_have_ff;
reg [7:0] awaddr_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;

wire single = (mode_ff == `PWMO_MODE_SINGLE);
wire centre = mode_ff[1]; // Modes 10 and 11 count up and down
wire per_hit = en_ff & (cnt_ff == period_ff);
wire zero_hit = (cnt_ff == {CW{1'b0}});
wire aw_take = AWVALID & AWREADY;
wire w_take = WVALID & WREADY;
wire do_wr = aw_have_ff & w_have_ff & ~BVALID;
wire ar_take = ARVALID & ARREADY;
wire wr_ok = do_wr & mapped(awaddr_ff);
wire [31:0] wimg = merge(32'h0, wdata_ff, wstrb_ff);
// Lane-merged images of the wide registers; only the low CW bits are kept
wire [31:0] per_img = merge({{(32-CW){1'b0}}, period_ff}, wdata_ff, wstrb_ff);
wire [31:0] duty0_img = merge({{(32-CW){1'b0}}, duty_ff[0]}, wdata_ff, wstrb_ff);
wire [31:0] duty1_img = merge({{(32-CW){1'b0}}, duty_ff[1]}, wdata_ff, wstrb_ff);
wire [31:0] duty2_img = merge({{(32-CW){1'b0}}, duty_ff[2]}, wdata_ff, wstrb_ff);

// A write of 1 to the enable bit in the same cycle as the end of a
// pulse keeps enable set but gives no start edge, so no pulse flag is raised
wire en_wr = wr_ok & (awaddr_ff == `PWMO_ADDR_TBCTL) & wstrb_ff[0];
wire start = en_ff & ~en_prev_ff;
wire sync_pt = zero_hit | (centre & (cnt_ff == period_ff));
wire pulse_end = single & per_hit;

// Register writes and hardware updates of software registers
always @(posedge CLK or posedge RST)
begin
	if (RST)
	begin
		mode_ff <= `PWMO_MODE_FREE;
		en_ff <= 1'b0;
		period_ff <= {CW{1'b0}};
		duty_ff[0] <= {CW{1'b0}};
		duty_ff[1] <= {CW{1'b0}};
		duty_ff[2] <= {CW{1'b0}};
		indep_ff <= 3'h0;
		sync_ff <= 1'b0;
		high_side_polarity_ff <= 1'b0;
		low_side_polarity_ff <= 1'b0;
		ovsel_ff <= `PWMO_RST_OVSEL;
		ovstate_ff <= `PWMO_RST_OVSTATE;
		dt_ff <= `PWMO_RST_DEADTIME;
		istat_ff <= 2'h0;
		imask_ff <= 2'h0;
	end
	else if (CE)
	begin
		// Hardware ends the pulse by dropping enable; periods kept
		if (pulse_end)
			en_ff <= 1'b0;
		if (en_wr)
		begin
			mode_ff <= wimg[`PWMO_TB_MODE_LSB +: 2];
			en_ff <= wimg[`PWMO_TB_EN_BIT];
		end
		if (wr_ok)
		begin
			case (awaddr_ff)
				`PWMO_ADDR_PERIOD:
					period_ff <= per_img[CW-1:0];
				`PWMO_ADDR_DUTY0:
					duty_ff[0] <= duty0_img[CW-1:0];
				`PWMO_ADDR_DUTY1:
					duty_ff[1] <= duty1_img[CW-1:0];
				`PWMO_ADDR_DUTY2:
					duty_ff[2] <= duty2_img[CW-1:0];
				`PWMO_ADDR_OCTL0:
					if (wstrb_ff[0]) indep_ff <= wdata_ff[2:0];
				`PWMO_ADDR_OCTL1:
					if (wstrb_ff[0])
					begin
						sync_ff <= wdata_ff[`PWMO_SYNC_BIT];
						high_side_polarity_ff <= wdata_ff[`PWMO_HIGH_SIDE_POLARITY_BIT];
						low_side_polarity_ff <= wdata_ff[`PWMO_LOW_SIDE_POLARITY_BIT];
					end
				`PWMO_ADDR_OVSEL:
					if (wstrb_ff[0]) ovsel_ff <= wdata_ff[5:0];
				`PWMO_ADDR_OVSTATE:
					if (wstrb_ff[0]) ovstate_ff <= wdata_ff[5:0];
				`PWMO_ADDR_DEADTIME:
					if (wstrb_ff[0]) dt_ff <= wdata_ff[DW-1:0];
				`PWMO_ADDR_IMASK:
					if (wstrb_ff[0]) imask_ff <= wdata_ff[1:0];
				default:
				begin
					// Status and time base control handled elsewhere; counter is read-only
				end
			endcase
		end
		// Write one to clear; an event in the same cycle wins
		istat_ff <= (istat_ff & ~((wr_ok && awaddr_ff == `PWMO_ADDR_ISTAT
			&& wstrb_ff[0]) ? wdata_ff[1:0] : 2'h0))
			| {per_hit, pulse_end};
	end
end

// Time base counter: edge-aligned wraps at period, centre counts back
always @(posedge CLK or posedge RST)
begin
	if (RST)
	begin
		cnt_ff <= {CW{1'b0}};
		down_ff <= 1'b0;
		en_prev_ff <= 1'b0;
	end
	else if (CE)
	begin
		en_prev_ff <= en_ff;
		if (!en_ff)
			down_ff <= 1'b0;
		else if (pulse_end)
			cnt_ff <= {CW{1'b0}};
		else if (!centre)
			cnt_ff <= per_hit ? {CW{1'b0}} : cnt_ff + {{(CW-1){1'b0}}, 1'b1};
		else if (per_hit || (down_ff && cnt_ff == {{(CW-1){1'b0}}, 1'b1}))
		begin
			// Turn around at period and one step above zero
			down_ff <= ~down_ff;
			cnt_ff <= per_hit ? cnt_ff - {{(CW-1){1'b0}}, 1'b1}
				: {CW{1'b0}};
		end
		else if (down_ff)
			cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
		else
			cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
	end
end

// Override settings in force: copied each clock, or only at sync points
always @(posedge CLK or posedge RST)
begin
	if (RST)
	begin
		ovsel_act_ff <= `PWMO_RST_OVSEL;
		ovstate_act_ff <= `PWMO_RST_OVSTATE;
	end
	else if (CE)
	begin
		if (!sync_ff)
		begin
			ovsel_act_ff <= ovsel_ff;
			ovstate_act_ff <= ovstate_ff;
		end
		else if (sync_pt)
		begin
			// Centre mode adds the period match as a second point
			ovsel_act_ff <= ovsel_ff;
			ovstate_act_ff <= ovstate_ff;
		end
	end
end

// Per-pair duty generator and pin request
genvar p;
generate
	for (p = 0; p < 3; p = p + 1)
	begin : g_pair
		wire duty_hit = (cnt_ff == duty_ff[p]);
		wire duty_on; // Duty comparator output for this pair
		wire odd_sel; // Odd pin request after override
		wire even_sel; // Even pin request after override
		wire odd_act; // Odd active level from dead time
		wire even_act; // Even active level from dead time

		// Single-pulse flag: on at enable, off at duty or period match
		always @(posedge CLK or posedge RST)
		begin
			if (RST)
				pulse_ff[p] <= 1'b0;
			else if (CE)
			begin
				if (!single || pulse_end || (en_ff && duty_hit))
					pulse_ff[p] <= 1'b0;
				else if (start)
					pulse_ff[p] <= 1'b1;
			end
		end

		// One generator serves both pins of the pair
		assign duty_on = single ? pulse_ff[p] : (en_ff & (cnt_ff < duty_ff[p]));
		assign odd_sel = ovsel_act_ff[2*p+1] ? duty_on : ovstate_act_ff[2*p+1];
		assign even_sel = ovsel_act_ff[2*p] ? duty_on : ovstate_act_ff[2*p];

		// Requests are registered so the dead-time unit sees clean edges
		always @(posedge CLK or posedge RST)
		begin
			if (RST)
				req_ff[2*p+1 -: 2] <= 2'b00;
			else if (CE)
				req_ff[2*p+1 -: 2] <= {odd_sel, even_sel};
		end

		// Complementary pairs ignore the even request entirely
		pwmo_deadtime #(.DW(DW)) u_dt
		(
			.clk(CLK),
			.rst(RST),
			.ce(CE),
			.odd_in(req_ff[2*p+1]),
			.even_in(req_ff[2*p]),
			.bypass(indep_ff[p]),
			.dt_val(dt_ff),
			.odd_ff(odd_act),
			.even_ff(even_act)
		);

		// Pin levels from the polarity bits
		always @(posedge CLK or posedge RST)
		begin
			if (RST)
				PWM_OUT[2*p+1 -: 2] <= 2'b00;
			else if (CE)
				PWM_OUT[2*p+1 -: 2] <= {odd_act ^ high_side_polarity_ff, even_act ^ low_side_polarity_ff};
		end
	end
endgenerate

// Interrupt line, one clock behind the status bits
always @(posedge CLK or posedge RST)
begin
	if (RST)
		IRQ <= 1'b0;
	else if (CE)
		IRQ <= |(istat_ff & imask_ff);
end

// Write channel: address and data taken in either order
always @(posedge CLK or posedge RST)
begin
	if (RST)
	begin
		aw_have_ff <= 1'b0;
		w_have_ff <= 1'b0;
		awaddr_ff <= 8'h00;
		wdata_ff <= 32'h0;
		wstrb_ff <= 4'h0;
		AWREADY <= 1'b0;
		WREADY <= 1'b0;
		BVALID <= 1'b0;
		BRESP <= `PWMO_RESP_OKAY;
	end
	else if (CE)
	begin
		if (aw_take)
		begin
			aw_have_ff <= 1'b1;
			awaddr_ff <= AWADDR;
		end
		if (w_take)
		begin
			w_have_ff <= 1'b1;
			wdata_ff <= WDATA;
			wstrb_ff <= WSTRB;
		end
		if (do_wr)
		begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			BVALID <= 1'b1;
			// Unmapped addresses are refused with a slave error
			BRESP <= mapped(awaddr_ff) ? `PWMO_RESP_OKAY : `PWMO_RESP_SLVERR;
		end
		else if (BVALID && BREADY)
			BVALID <= 1'b0;
		// Ready again only once the previous response is gone
		AWREADY <= ~aw_have_ff & ~aw_take & ~BVALID & ~do_wr;
		WREADY <= ~w_have_ff & ~w_take & ~BVALID & ~do_wr;
	end
end

// Read channel: one read at a time, data registered
always @(posedge CLK or posedge RST)
begin
	if (RST)
	begin
		ARREADY <= 1'b0;
		RVALID <= 1'b0;
		RDATA <= 32'h0;
		RRESP <= `PWMO_RESP_OKAY;
	end
	else if (CE)
	begin
		if (ar_take)
		begin
			RVALID <= 1'b1;
			RRESP <= mapped(ARADDR) ? `PWMO_RESP_OKAY : `PWMO_RESP_SLVERR;
			case (ARADDR)
				`PWMO_ADDR_TBCTL: RDATA <= {24'h0, en_ff, 5'h0, mode_ff};
				`PWMO_ADDR_PERIOD: RDATA <= {{(32-CW){1'b0}}, period_ff};
				`PWMO_ADDR_DUTY0: RDATA <= {{(32-CW){1'b0}}, duty_ff[0]};
				`PWMO_ADDR_DUTY1: RDATA <= {{(32-CW){1'b0}}, duty_ff[1]};
				`PWMO_ADDR_DUTY2: RDATA <= {{(32-CW){1'b0}}, duty_ff[2]};
				`PWMO_ADDR_OCTL0: RDATA <= {29'h0, indep_ff};
				`PWMO_ADDR_OCTL1: RDATA <= {29'h0, low_side_polarity_ff, high_side_polarity_ff, sync_ff};
				`PWMO_ADDR_OVSEL: RDATA <= {26'h0, ovsel_ff};
				`PWMO_ADDR_OVSTATE: RDATA <= {26'h0, ovstate_ff};
				`PWMO_ADDR_DEADTIME: RDATA <= {{(32-DW){1'b0}}, dt_ff};
				`PWMO_ADDR_ISTAT: RDATA <= {30'h0, istat_ff};
				`PWMO_ADDR_IMASK: RDATA <= {30'h0, imask_ff};
				`PWMO_ADDR_COUNT: RDATA <= {{(32-CW){1'b0}}, cnt_ff};
				default: RDATA <= 32'h0;
			endcase
		end
		else if (RVALID && RREADY)
			RVALID <= 1'b0;
		ARREADY <= ~ar_take & ~(RVALID & ~RREADY);
	end
end

endmodule

/* File: verilog/pwmo_regs.vh */
// Register map, field positions and reset values of the PWM output block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
//
// Summary of operation
// - Pair mode bit set selects independent mode
// - Independent pairs: no dead time, both active
// - Duty value N drives both pins of pair N
// - Mode field 01 gives edge-aligned single pulse
// - Enable drives pins active, duty match ends them
// - Period match clears timer, pins, enable; interrupt
// - Period and duty kept; re-enable for next pulse
// - Six active-low override select bits, one per output
// - Overridden pin follows its manual state bit; complementary even pin ignores it
// - Complementary even pin complements odd pin outside the dead band
// - Even never active while odd is active
// - Dead time kept under manual override
// - Synced overrides apply at counter zero, edge-aligned
// - Centre-aligned sync at zero and at period
// - Select resets ones, state zeros, top bits zero
// - Odd override: even off, dead time, odd on
// - Polarity bits set active level per side
`ifndef PWMO_REGS_VH
`define PWMO_REGS_VH

// Byte addresses of the registers
`define PWMO_ADDR_TBCTL 8'h00
`define PWMO_ADDR_PERIOD 8'h04
`define PWMO_ADDR_DUTY0 8'h08
`define PWMO_ADDR_DUTY1 8'h0c
`define PWMO_ADDR_DUTY2 8'h10
`define PWMO_ADDR_OCTL0 8'h14
`define PWMO_ADDR_OCTL1 8'h18
`define PWMO_ADDR_OVSEL 8'h1c
`define PWMO_ADDR_OVSTATE 8'h20
`define PWMO_ADDR_DEADTIME 8'h24
`define PWMO_ADDR_ISTAT 8'h28
`define PWMO_ADDR_IMASK 8'h2c
`define PWMO_ADDR_COUNT 8'h30

// Time base control fields
`define PWMO_TB_MODE_LSB 0
`define PWMO_TB_EN_BIT 7
`define PWMO_MODE_FREE 2'b00
`define PWMO_MODE_SINGLE 2'b01

// Output control 1 fields
`define PWMO_SYNC_BIT 0
`define PWMO_HIGH_SIDE_POLARITY_BIT 1
`define PWMO_LOW_SIDE_POLARITY_BIT 2

// Interrupt status bits
`define PWMO_IRQ_PULSE_BIT 0
`define PWMO_IRQ_PERIOD_BIT 1

// Reset values
`define PWMO_RST_OVSEL 6'h3f
`define PWMO_RST_OVSTATE 6'h00
`define PWMO_RST_DEADTIME 6'h00

// AXI responses
`define PWMO_RESP_OKAY 2'b00
`define PWMO_RESP_SLVERR 2'b10

`endif

/* File: verilog/pwmo_deadtime.v */
// Dead-time unit for one output pair.
// Assumes its input is the odd pin's wanted active level, registered.
`timescale 1ns/1ns
module pwmo_deadtime
#(
	parameter DW = 6
)
(
	input wire clk,
	input wire rst,
	input wire ce,
	input wire odd_in, // Wanted active level of the odd pin
	input wire even_in, // Even pin level used when bypassed
	input wire bypass, // Independent pair: no dead time
	input wire [DW-1:0] dt_val, // Dead time in clock cycles
	output reg odd_ff, // Odd pin active level
	output reg even_ff // Even pin active level
);

reg prev_ff; // Last seen odd request, for edge detection
reg [DW-1:0] cnt_ff; // Dead-time down counter
wire edge_seen; // Odd request changed this cycle
wire settled; // Dead time fully elapsed

assign edge_seen = (odd_in != prev_ff);
assign settled = ~edge_seen & (cnt_ff == {DW{1'b0}});

// Every edge reloads the counter, so a toggle inside the dead time
// restarts it rather than letting a pin slip through early
always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		prev_ff <= 1'b0;
		cnt_ff <= {DW{1'b0}};
		odd_ff <= 1'b0;
		even_ff <= 1'b0;
	end
	else if (ce)
	begin
		prev_ff <= odd_in;
		if (edge_seen)
			cnt_ff <= dt_val;
		else if (cnt_ff != {DW{1'b0}})
			cnt_ff <= cnt_ff - {{(DW-1){1'b0}}, 1'b1};
		if (bypass)
		begin
			// Both pins free to be active together
			odd_ff <= odd_in;
			even_ff <= even_in;
		end
		else
		begin
			// Both off on any edge, new side on only after dead time
			odd_ff <= odd_in & settled;
			even_ff <= ~odd_in & settled;
		end
	end
end

endmodule

/* File: tb/pwmo_props.sv */
// Checker for the PWM output block: bus handshakes and leg safety.
// Assumes it is bound to pwmo_top; pair mode and polarity are snooped off bus writes.
`timescale 1ns/1ns
`include "pwmo_regs.vh"
module pwmo_props
(
	input wire CLK,
	input wire RST,
	input wire CE,
	input wire [7:0] AWADDR,
	input wire AWVALID,
	input wire AWREADY,
	input wire [31:0] WDATA,
	input wire WVALID,
	input wire WREADY,
	input wire [1:0] BRESP,
	input wire BVALID,
	input wire BREADY,
	input wire [7:0] ARADDR,
	input wire ARVALID,
	input wire ARREADY,
	input wire [31:0] RDATA,
	input wire [1:0] RRESP,
	input wire RVALID,
	input wire RREADY,
	input wire [5:0] PWM_OUT
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// Address and data taken at one edge
	wire w_take = CE && AWVALID && AWREADY && WVALID && WREADY;
	wire mode_wr = w_take && (AWADDR == 8'h14 || AWADDR == 8'h18);
	reg [2:0] indep_ff; // Pairs run independently
	reg [1:0] pol_ff; // High and low side polarity
	reg [3:0] quiet_ff; // Settling count; pins lag a mode change
	wire [5:0] act = PWM_OUT ^ {3{pol_ff}};
	wire shoot = |({act[5], act[3], act[1]} & {act[4], act[2], act[0]} & ~indep_ff);
	// Shadow the mode registers from the bus
	always @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			indep_ff <= 3'h0;
			pol_ff <= 2'h0;
			quiet_ff <= 4'h0;
		end
		else if (mode_wr)
		begin
			quiet_ff <= 4'h0;
			if (AWADDR == 8'h14)
				indep_ff <= WDATA[2:0];
			else
				pol_ff <= {WDATA[1], WDATA[2]};
		end
		else if (quiet_ff != 4'hf)
			quiet_ff <= quiet_ff + 4'h1;
	end
	sequence s_ar_take;
		CE && ARVALID && ARREADY;
	endsequence
	property p_wr_answer;
		w_take |=> (!AWREADY && !WREADY) ##1 (BVALID && !AWREADY && !WREADY);
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_wr_err;
		w_take && AWADDR > 8'h30 |=> ##1 (BVALID && BRESP == `PWMO_RESP_SLVERR);
	endproperty
	a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
	property p_b_hold;
		CE && BVALID && !BREADY |=> BVALID && $stable(BRESP);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_rd_answer;
		s_ar_take |=> RVALID && !ARREADY;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_rd_err;
		s_ar_take ##0 (ARADDR > 8'h30) |=> RRESP == `PWMO_RESP_SLVERR && RDATA == 32'h0;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
	property p_r_hold;
		CE && RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_ar_busy;
		RVALID |-> !ARREADY;
	endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
	property p_no_shoot;
		quiet_ff == 4'hf |-> !shoot;
	endproperty
	a_no_shoot: assert property (p_no_shoot) else $error("both pins of a pair active");
endmodule
bind pwmo_top pwmo_props u_props (.CLK(CLK), .RST(RST), .CE(CE), .AWADDR(AWADDR),
	.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WVALID(WVALID), .WREADY(WREADY),
	.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
	.PWM_OUT(PWM_OUT));

/* File: tb/pwmo_inverter.sv */
// Inverter stage model: one leg per output pair, odd pin on the high side.
// Assumes active-high gate drive; counts cycles with both switches of a watched leg on.
`timescale 1ns/1ns
module pwmo_inverter
(
	input wire clk,
	input wire [5:0] gate, // Gate drives from the block
	input wire [2:0] watch, // Legs where overlap would short the rail
	output reg [31:0] shoot_count // Overlap cycles seen
);
	initial
		shoot_count = 32'h0;
	// Independent legs drive separate loads, so only watched legs count
	always @(posedge clk)
	begin
		if (|({gate[5], gate[3], gate[1]} & {gate[4], gate[2], gate[0]} & watch))
			shoot_count <= shoot_count + 32'h1;
	end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the PWM output block over AXI4-Lite.
// Assumes pwmo_top with default parameters and the inverter model on its pins.
`timescale 1ns/1ns
`include "pwmo_regs.vh"
module tb_top;
	reg clk, rst;
	reg [7:0] awaddr, araddr;
	reg [31:0] wdata, d;
	reg awvalid, wvalid, bready, arvalid, rready;
	wire awready, wready, bvalid, arready, rvalid, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata, shoot;
	wire [5:0] pwm_out;
	reg [2:0] watch;
	reg [1:0] resp;
	integer fail_count, check_count, h1, h0, i, gap;
	pwmo_top dut (.CLK(clk), .RST(rst), .CE(1'b1), .AWADDR(awaddr), .AWVALID(awvalid),
		.AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.PWM_OUT(pwm_out), .IRQ(irq));
	pwmo_inverter model (.clk(clk), .gate(pwm_out), .watch(watch), .shoot_count(shoot));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Cycles with both pins of pair 0 inactive, i.e. the dead band
	always @(posedge clk)
		if (pwm_out[1:0] === 2'b00)
			gap = gap + 1;
	task print_verdict;
	begin
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] want);
	begin
		check_count = check_count + 1;
		if (seen !== want)
		begin
			fail_count = fail_count + 1;
			$display("MISMATCH %s expected %h seen %h", nm, want, seen);
		end
	end
	endtask
	// A hung handshake ends the run
	task tmo;
	begin
		fail_count = fail_count + 1;
		$display("MISMATCH handshake expected answer seen none");
		print_verdict;
	end
	endtask
	// Write: both channels offered, each released once taken
	task wr(input [7:0] a, input [31:0] v);
		integer n;
	begin
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// Ready raised only once the answer shows, so the slave must hold it
		for (n = 0; n < 20; n = n + 1)
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
			begin
				bready <= 1'b0;
				resp = bresp;
				n = 99;
			end
			else if (bvalid)
				bready <= 1'b1;
		end
		if (n == 20)
			tmo;
		@(posedge clk);
	end
	endtask
	task rd(input [7:0] a);
		integer n;
	begin
		araddr <= a;
		arvalid <= 1'b1;
		// Late ready makes the slave hold its read data one cycle
		for (n = 0; n < 20; n = n + 1)
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
			begin
				rready <= 1'b0;
				d = rdata;
				resp = rresp;
				n = 99;
			end
			else if (rvalid)
				rready <= 1'b1;
		end
		if (n == 20)
			tmo;
		@(posedge clk);
	end
	endtask
	task waitp(input [5:0] m, input [5:0] e, input integer lim);
		integer n;
	begin
		for (n = 0; n < lim && (pwm_out & m) !== e; n = n + 1)
			@(posedge clk);
		chk("pins", pwm_out & m, e);
		if (n == lim)
			print_verdict;
	end
	endtask
	// Active cycles of pins 1 and 0 over a window
	task sample(input integer cyc);
		integer n;
	begin
		h1 = 0;
		h0 = 0;
		for (n = 0; n < cyc; n = n + 1)
		begin
			@(posedge clk);
			h1 = h1 + pwm_out[1];
			h0 = h0 + pwm_out[0];
		end
	end
	endtask
	initial
	begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		watch = 3'h0;
		gap = 0;
		fail_count = 0;
		check_count = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rd(8'h1c);
		chk("select reset", d, 32'h3f);
		rd(8'h20);
		chk("state reset", d, 32'h0);
		wr(8'h20, 32'hffffffff);
		rd(8'h20);
		chk("state top bits", d, 32'h3f);
		rd(8'h40);
		chk("unmapped", {resp, d[29:0]}, {`PWMO_RESP_SLVERR, 30'h0});
		wr(8'h40, 32'h1);
		chk("unmapped write", resp, `PWMO_RESP_SLVERR);
		$display("test registers done");
		wr(8'h14, 32'h7);
		wr(8'h20, 32'h15);
		wr(8'h1c, 32'h0);
		waitp(6'h3f, 6'h15, 8);
		wr(8'h18, 32'h6);
		waitp(6'h3f, 6'h2a, 8);
		wr(8'h18, 32'h0);
		wr(8'h1c, 32'h3f);
		wr(8'h20, 32'h0);
		$display("test override done");
		wr(8'h04, 32'd30);
		wr(8'h08, 32'd10);
		wr(8'h2c, 32'h1);
		for (i = 0; i < 2; i = i + 1)
		begin
			wr(8'h00, 32'h81);
			sample(60);
			chk("pulse width", h1, 10);
			chk("pulse irq", irq, i == 0);
			rd(8'h28);
			chk("pulse status", d[0], 1'b1);
			rd(8'h00);
			chk("enable cleared", d, 32'h1);
			rd(8'h30);
			chk("timer cleared", d, 32'h0);
			wr(8'h28, 32'h3);
			chk("irq cleared", irq, 1'b0);
			wr(8'h2c, 32'h0);
		end
		rd(8'h28);
		chk("status cleared", d[1:0], 2'h0);
		rd(8'h08);
		chk("duty kept", d, 32'd10);
		$display("test single pulse done");
		wr(8'h04, 32'd20);
		wr(8'h08, 32'd5);
		wr(8'h0c, 32'h0);
		wr(8'h10, 32'hfff);
		wr(8'h00, 32'h80);
		for (i = 7; i > 5; i = i - 1)
		begin
			wr(8'h14, i);
			repeat (30) @(posedge clk);
			sample(21);
			// A complementary pair loses one cycle at each turn-on to the dead band
			chk("odd count", h1, i[0] ? 5 : 4);
			chk("even count", h0, i[0] ? 5 : 15);
		end
		chk("pairs 1 2", pwm_out[5:2], 4'hc);
		$display("test independent done");
		// Override pending while the frozen counter equals the period
		wr(8'h20, 32'h30);
		wr(8'h18, 32'h1);
		wr(8'h00, 32'h0);
		rd(8'h30);
		wr(8'h04, d);
		wr(8'h1c, 32'h0f);
		repeat (20) @(posedge clk);
		chk("held by sync", pwm_out[5:4], (d == 32'h0) ? 2'h3 : 2'h0);
		// Centre counting adds the period match as a sync point
		wr(8'h00, 32'h2);
		waitp(6'h30, 6'h30, 20);
		wr(8'h00, 32'h0);
		wr(8'h04, 32'd20);
		wr(8'h20, 32'h0);
		wr(8'h00, 32'h80);
		waitp(6'h30, 6'h00, 40);
		wr(8'h00, 32'h0);
		wr(8'h18, 32'h0);
		$display("test sync done");
		wr(8'h14, 32'h0);
		wr(8'h24, 32'h4);
		wr(8'h1c, 32'h3c);
		repeat (20) @(posedge clk);
		watch <= 3'h7;
		gap = 0;
		wr(8'h20, 32'h2);
		waitp(6'h03, 6'h02, 20);
		chk("dead band on", gap >= 4, 1'b1);
		gap = 0;
		wr(8'h20, 32'h0);
		waitp(6'h03, 6'h01, 20);
		chk("dead band off", gap >= 4, 1'b1);
		wr(8'h20, 32'h3);
		waitp(6'h03, 6'h02, 20);
		chk("shoot-through", shoot, 32'h0);
		$display("test complementary done");
		print_verdict;
	end
endmodule
